// ===== rtl/pols_defines.svh
// Register offsets, field masks, reset values and bus codes of the pin output latch.
`ifndef POLS_DEFINES_SVH
`define POLS_DEFINES_SVH

`define POLS_ADDR_W          8
`define POLS_ADDR_FUNC       8'h10
`define POLS_ADDR_DIR        8'h14
`define POLS_ADDR_VALUE      8'h18
`define POLS_ADDR_LEVEL      8'h1c
`define POLS_ADDR_SET        8'h20
`define POLS_ADDR_CLR        8'h24

`define POLS_RSVD_MASK       32'h01ff0000
`define POLS_RESET_WORD      32'h00000000
`define POLS_ZERO_WORD       32'h00000000

`define POLS_HTRANS_NONSEQ   2'h2
`define POLS_HSIZE_WORD      3'h2
`define POLS_HRESP_OKAY      1'h0
`define POLS_HREADY_ALWAYS   1'h1

`endif

// ===== rtl/pols_pkg.sv
// Types shared by the pin output latch files.
`default_nettype none

package pols_pkg;

   // Pin order of every 32-bit pin word, most significant field first.
   typedef struct packed {
      logic        rxFrameSync;
      logic        rxHighClock;
      logic        rxBitClock;
      logic        txFrameSync;
      logic        txHighClock;
      logic        txBitClock;
      logic        mute;
      logic [8:0]  reserved;
      logic [15:0] serialData;
   } pols_pins_s;

   // Address phase held over into the data phase of an AHB-Lite transfer.
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } pols_addr_phase_s;

   // Mode bits of one pin: general-purpose use and output direction.
   typedef struct packed {
      logic gpio;
      logic drive;
   } pols_pin_mode_s;

endpackage

`default_nettype wire

// ===== rtl/pols_pin_sync.sv
// Two-stage synchroniser for the live pin levels.
`timescale 1ns/1ps
`default_nettype none
`include "pols_defines.svh"

module pols_pin_sync
   import pols_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic [31:0] pinIn,
   output var  logic [31:0] pinLevel
);

   logic [31:0] firstStage;

   // The first stage feeds only the second, so a metastable level never spreads.
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         firstStage <= `POLS_ZERO_WORD;
         pinLevel   <= `POLS_ZERO_WORD;
      end
      else
      begin
         firstStage <= pinIn;
         pinLevel   <= firstStage;
      end
   end

endmodule // pols_pin_sync

`default_nettype wire

// ===== rtl/pols_gpio_latch.sv
// Pin output latch with set and clear aliases, pin controls and AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "pols_defines.svh"

// What this block does
// R1: The output value register always holds its data and reads back.
// R2: Writing direction or function select leaves the output value unchanged.
// R3: A pin is driven only when function select and direction are both one.
// R4: Direct address reads stored bits, not pin levels; writes load storage.
// R5: Set alias write forces ones where written bits are one.
// R6: Clear alias write forces zeros where written bits are one.
// R7: Direct, set and clear addresses share one set of 32 bits.
// R8: Reserved bits 24 to 16 read zero and ignore writes.
// R9: Software writes only zeros into reserved and unimplemented bits.
// R10: Bits map to data pins, mute, then transmit and receive clocks and syncs.
// R11: An enabled pin drives low for a stored zero, high for a one.
// R12: Reset clears the whole output storage to zero.
module pols_gpio_latch
   import pols_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   input  wire logic [31:0] pinIn,
   output var  logic [31:0] pinOut,
   output var  logic [31:0] pinOe
);

   pols_addr_phase_s addrPhase;
   pols_pins_s       outValue;
   pols_pins_s       next_outValue;
   logic [31:0]      funcSel;
   logic [31:0]      next_funcSel;
   logic [31:0]      dirSel;
   logic [31:0]      next_dirSel;
   logic [31:0]      pinLevel;
   logic [31:0]      wrData;
   logic [31:0]      rdWord;
   logic             accept;
   logic             wrEn;

   // Zero wait states, so the slave is always ready and always answers OKAY.
   assign hreadyout = `POLS_HREADY_ALWAYS;
   assign hresp     = `POLS_HRESP_OKAY;

   // Only single word transfers are taken; other sizes pass as idle.
   assign accept = hsel && hready && (htrans == `POLS_HTRANS_NONSEQ)
                   && (hsize == `POLS_HSIZE_WORD);

   assign wrEn   = addrPhase.valid && addrPhase.write;

   // Reserved lanes are stripped on the way in, so stray ones never land.
   assign wrData = hwdata & ~`POLS_RSVD_MASK;  // [R8]

   pols_pin_sync u_pin_sync
   (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .pinIn    (pinIn),
      .pinLevel (pinLevel)
   );

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         addrPhase <= '0;
      end
      else if (hready)
      begin
         addrPhase.valid <= accept;
         addrPhase.write <= hwrite;
         addrPhase.addr  <= haddr[`POLS_ADDR_W-1:0];
      end
   end

   // One store serves all three addresses; they differ only in the write merge.
   always_comb
   begin
      next_outValue = outValue;
      if (wrEn)
      begin
         if (addrPhase.addr == `POLS_ADDR_VALUE)
         begin
            next_outValue = pols_pins_s'(wrData);  // [R4] [R7]
         end
         else if (addrPhase.addr == `POLS_ADDR_SET)
         begin
            next_outValue = pols_pins_s'(outValue | wrData);  // [R5] [R7]
         end
         else if (addrPhase.addr == `POLS_ADDR_CLR)
         begin
            next_outValue = pols_pins_s'(outValue & ~wrData);  // [R6] [R7]
         end
         else
         begin
            next_outValue = outValue;  // [R2]
         end
      end
   end

   always_comb
   begin
      next_funcSel = funcSel;
      next_dirSel  = dirSel;
      if (wrEn)
      begin
         if (addrPhase.addr == `POLS_ADDR_FUNC)
         begin
            next_funcSel = wrData;
         end
         else if (addrPhase.addr == `POLS_ADDR_DIR)
         begin
            next_dirSel = wrData;
         end
      end
   end

   // The output store keeps its value until a write to one of its addresses.
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         outValue <= pols_pins_s'(`POLS_RESET_WORD);  // [R12]
      end
      else
      begin
         outValue <= next_outValue;  // [R1]
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         funcSel <= `POLS_RESET_WORD;
         dirSel  <= `POLS_RESET_WORD;
      end
      else
      begin
         funcSel <= next_funcSel;
         dirSel  <= next_dirSel;
      end
   end

   // Reads decode against next values, so a write just before a read is seen.
   always_comb
   begin
      rdWord = `POLS_ZERO_WORD;
      if (haddr[`POLS_ADDR_W-1:0] == `POLS_ADDR_VALUE)
      begin
         rdWord = next_outValue;  // [R1] [R4]
      end
      else if (haddr[`POLS_ADDR_W-1:0] == `POLS_ADDR_SET)
      begin
         rdWord = next_outValue;  // [R7]
      end
      else if (haddr[`POLS_ADDR_W-1:0] == `POLS_ADDR_CLR)
      begin
         rdWord = next_outValue;  // [R7]
      end
      else if (haddr[`POLS_ADDR_W-1:0] == `POLS_ADDR_FUNC)
      begin
         rdWord = next_funcSel;
      end
      else if (haddr[`POLS_ADDR_W-1:0] == `POLS_ADDR_DIR)
      begin
         rdWord = next_dirSel;
      end
      else if (haddr[`POLS_ADDR_W-1:0] == `POLS_ADDR_LEVEL)
      begin
         rdWord = pinLevel & ~`POLS_RSVD_MASK;
      end
      else
      begin
         rdWord = `POLS_ZERO_WORD;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         hrdata <= `POLS_ZERO_WORD;
      end
      else if (accept && !hwrite)
      begin
         hrdata <= rdWord & ~`POLS_RSVD_MASK;  // [R8]
      end
   end

   // Pin drive: the data flop goes straight out, the enable picks the owner.
   // The field order of the pin word fixes which pin each bit reaches.
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1)
      begin : g_pin
         pols_pin_mode_s mode;
         assign mode.gpio  = funcSel[gi];
         assign mode.drive = dirSel[gi];
         assign pinOut[gi] = outValue[gi];  // [R10] [R11]
         assign pinOe[gi]  = mode.gpio && mode.drive;  // [R3]

         // Pin checks start from bus data, so a wrong merge or a swapped bit shows here.
         a_pin_level: assert property (  // [R11]
            @(posedge mclk) disable iff (!reset_n)
            ($past(wrEn && (addrPhase.addr == `POLS_ADDR_SET) && hwdata[gi]) && pinOe[gi])
            |-> pinOut[gi]
         ) else $error("Enabled pin not high after its bit was set.");

         a_pin_low: assert property (  // [R11]
            @(posedge mclk) disable iff (!reset_n)
            ($past(wrEn && (addrPhase.addr == `POLS_ADDR_CLR) && hwdata[gi]) && pinOe[gi])
            |-> !pinOut[gi]
         ) else $error("Enabled pin not low after its bit was cleared.");
      end
   endgenerate

   a_pin_enable: assert property (  // [R3]
      @(posedge mclk) disable iff (!reset_n)
      (wrEn && (addrPhase.addr == `POLS_ADDR_DIR))
      |=> (pinOe == ($past(funcSel) & $past(hwdata) & ~`POLS_RSVD_MASK))
   ) else $error("Pin enable does not follow a direction write.");

   a_func_write: assert property (  // [R3]
      @(posedge mclk) disable iff (!reset_n)
      (wrEn && (addrPhase.addr == `POLS_ADDR_FUNC))
      |=> (pinOe == ($past(hwdata) & $past(dirSel) & ~`POLS_RSVD_MASK))
   ) else $error("Pin enable does not follow a function select write.");

   a_idle_pins: assert property (  // [R3]
      @(posedge mclk) disable iff (!reset_n)
      !(wrEn && ((addrPhase.addr == `POLS_ADDR_FUNC)
                 || (addrPhase.addr == `POLS_ADDR_DIR)))
      |=> $stable(pinOe)
   ) else $error("Pin enable changed without a control write.");

   a_value_read: assert property (  // [R1]
      @(posedge mclk) disable iff (!reset_n)
      (addrPhase.valid && !addrPhase.write
       && (addrPhase.addr == `POLS_ADDR_VALUE))
      |-> (hrdata == outValue)
   ) else $error("Direct read did not return the stored bits.");

   a_ctl_keep: assert property (  // [R2]
      @(posedge mclk) disable iff (!reset_n)
      (wrEn && ((addrPhase.addr == `POLS_ADDR_FUNC)
                || (addrPhase.addr == `POLS_ADDR_DIR)))
      |=> (outValue == $past(outValue))
   ) else $error("Control write disturbed the output store.");

   a_direct_write: assert property (  // [R4]
      @(posedge mclk) disable iff (!reset_n)
      (wrEn && (addrPhase.addr == `POLS_ADDR_VALUE))
      |=> (outValue == ($past(hwdata) & ~`POLS_RSVD_MASK))
   ) else $error("Direct write did not load the store.");

   a_set_write: assert property (  // [R5]
      @(posedge mclk) disable iff (!reset_n)
      (wrEn && (addrPhase.addr == `POLS_ADDR_SET))
      |=> (outValue == ($past(outValue)
                        | ($past(hwdata) & ~`POLS_RSVD_MASK)))
   ) else $error("Set alias write merged wrongly.");

   a_clear_write: assert property (  // [R6]
      @(posedge mclk) disable iff (!reset_n)
      (wrEn && (addrPhase.addr == `POLS_ADDR_CLR))
      |=> (outValue == ($past(outValue) & ~$past(hwdata)))
   ) else $error("Clear alias write merged wrongly.");

   a_alias_shared: assert property (  // [R7]
      @(posedge mclk) disable iff (!reset_n)
      (accept && !hwrite && (haddr[`POLS_ADDR_W-1:0] == `POLS_ADDR_SET))
      ##1 (addrPhase.valid && !wrEn)
      |-> (hrdata == outValue)
   ) else $error("Set alias read differs from the direct store.");

   a_rsvd_zero: assert property (  // [R8]
      @(posedge mclk) disable iff (!reset_n)
      ((outValue & `POLS_RSVD_MASK) == `POLS_ZERO_WORD)
      && ((hrdata & `POLS_RSVD_MASK) == `POLS_ZERO_WORD)
   ) else $error("Reserved bits became nonzero.");

   a_reset_clear: assert property (  // [R12]
      @(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> (outValue == `POLS_RESET_WORD) && (pinOe == `POLS_ZERO_WORD)
   ) else $error("Output store not clear after reset.");

   a_idle_hold: assert property (  // [R1]
      @(posedge mclk) disable iff (!reset_n)
      (!addrPhase.valid && !accept)
      |=> (outValue == $past(outValue))
   ) else $error("Output store changed without a write.");

   // Byte and halfword writes are dropped silently; software sees no error for them.
   a_size_refused: assert property (  // [R1]
      @(posedge mclk) disable iff (!reset_n)
      (hsel && hready && (htrans == `POLS_HTRANS_NONSEQ) && (hsize != `POLS_HSIZE_WORD))
      |=> ##1 (outValue == $past(outValue))
   ) else $error("A refused transfer size changed the output store.");

   a_read_hold: assert property (  // [R1]
      @(posedge mclk) disable iff (!reset_n)
      !(accept && !hwrite) |=> $stable(hrdata)
   ) else $error("Read data changed without a read.");

   a_clear_read: assert property (  // [R7]
      @(posedge mclk) disable iff (!reset_n)
      (addrPhase.valid && !addrPhase.write
       && (addrPhase.addr == `POLS_ADDR_CLR))
      |-> (hrdata == outValue)
   ) else $error("Clear alias read differs from the direct store.");

   a_set_keep: assert property (  // [R5]
      @(posedge mclk) disable iff (!reset_n)
      (wrEn && (addrPhase.addr == `POLS_ADDR_SET))
      |=> (((outValue ^ $past(outValue)) & ~$past(hwdata)) == `POLS_ZERO_WORD)
   ) else $error("Set alias write changed a bit written as zero.");

   a_clear_keep: assert property (  // [R6]
      @(posedge mclk) disable iff (!reset_n)
      (wrEn && (addrPhase.addr == `POLS_ADDR_CLR))
      |=> (((outValue ^ $past(outValue)) & ~$past(hwdata)) == `POLS_ZERO_WORD)
   ) else $error("Clear alias write changed a bit written as zero.");

   // This one runs through reset on purpose, so it has no disable condition.
   a_reset_store: assert property (  // [R12]
      @(posedge mclk)
      !reset_n |=> (outValue == `POLS_RESET_WORD) && (hrdata == `POLS_ZERO_WORD)
                   && (pinOe == `POLS_ZERO_WORD)
   ) else $error("Reset did not clear the store, read data and pin enables.");

endmodule // pols_gpio_latch

`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking testbench for the pin output latch over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pols_defines.svh"

module tb_top
   import pols_pkg::*;
   ;
   logic        mclk      = 1'h0;
   logic        reset_n   = 1'h0;
   logic        hsel      = 1'h0;
   logic [31:0] haddr     = 32'h0;
   logic [1:0]  htrans    = 2'h0;
   logic        hwrite    = 1'h0;
   logic [2:0]  hsize     = 3'h2;
   logic [31:0] hwdata    = 32'h0;
   logic [31:0] pinIn     = 32'h0;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [31:0] pinOut;
   logic [31:0] pinOe;
   logic [31:0] store     = 32'h0;
   logic [31:0] funcR     = 32'h0;
   logic [31:0] dirR      = 32'h0;
   logic [31:0] d;
   logic [31:0] expQ[$];
   logic [7:0]  addrs[3]  = '{`POLS_ADDR_VALUE, `POLS_ADDR_SET, `POLS_ADDR_CLR};
   logic        rdPend    = 1'h0;
   int          errors    = 0;
   int          cmpCount  = 0;
   int          i;

   assign hready = hreadyout;
   always #20 mclk = ~mclk;

   pols_gpio_latch uut
   (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .pinIn     (pinIn),
      .pinOut    (pinOut),
      .pinOe     (pinOe)
   );

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic wr, input logic [2:0] sz,
                      input logic [31:0] dat);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= sz;
      htrans <= `POLS_HTRANS_NONSEQ;
      do @(posedge mclk); while (hready !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= wr ? dat : 32'h0;
      do @(posedge mclk); while (hready !== 1'h1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expQ.push_back(exp);
      bus(a, 1'h0, `POLS_HSIZE_WORD, 32'h0);
   endtask

   // Writes through the bus and keeps the bench's own copy of the registers in step.
   task automatic wmod(input logic [7:0] a, input logic [31:0] dat);
      bus(a, 1'h1, `POLS_HSIZE_WORD, dat);
      case (a)
         `POLS_ADDR_VALUE: store = dat & ~`POLS_RSVD_MASK;
         `POLS_ADDR_SET:   store = store | (dat & ~`POLS_RSVD_MASK);
         `POLS_ADDR_CLR:   store = store & ~dat;
         `POLS_ADDR_FUNC:  funcR = dat & ~`POLS_RSVD_MASK;
         `POLS_ADDR_DIR:   dirR = dat & ~`POLS_RSVD_MASK;
         default: ;
      endcase
   endtask

   task automatic chk_pins;
      @(posedge mclk);
      @(negedge mclk);
      cmp("pinOut", store, pinOut);
      cmp("pinOe", funcR & dirR, pinOe);
      cmp("hresp", 32'h0, {31'h0, hresp});
      @(posedge mclk);
   endtask

   task automatic test_done;
      $display("comparisons %0d errors %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Read data are taken at the edge that ends the data phase.
   always @(posedge mclk)
   begin
      if (rdPend && hready === 1'h1 && expQ.size() > 0)
         cmp("hrdata", expQ.pop_front(), hrdata);
      if (hready === 1'h1)
         rdPend = reset_n && hsel && htrans == `POLS_HTRANS_NONSEQ && !hwrite
                  && hsize == `POLS_HSIZE_WORD;
   end

   initial
   begin
      repeat (5000) @(posedge mclk);
      errors++;
      $display("mismatch watchdog expected finish seen timeout");
      test_done;
   end

   initial
   begin
      void'($urandom(32'h07fa));
      repeat (2) @(posedge mclk);
      reset_n <= 1'h1;
      @(posedge mclk);
      rd(`POLS_ADDR_VALUE, 32'h0);
      rd(`POLS_ADDR_FUNC, 32'h0);
      chk_pins;
      wmod(`POLS_ADDR_VALUE, 32'hffffffff);
      rd(`POLS_ADDR_VALUE, store);
      wmod(`POLS_ADDR_CLR, 32'hffffffff);
      rd(`POLS_ADDR_SET, store);
      for (i = 0; i < 12; i++)
      begin
         d = $urandom() & ~`POLS_RSVD_MASK;
         wmod(addrs[$urandom_range(2)], d);
         rd(addrs[$urandom_range(2)], store);
      end
      for (i = 0; i < 3; i++)
      begin
         wmod(`POLS_ADDR_FUNC, $urandom() & ~`POLS_RSVD_MASK);
         wmod(`POLS_ADDR_DIR, $urandom() & ~`POLS_RSVD_MASK);
         rd(`POLS_ADDR_VALUE, store);
         chk_pins;
         wmod(addrs[1 + i % 2], $urandom() & ~`POLS_RSVD_MASK);
         chk_pins;
      end
      pinIn <= ~store;
      repeat (3) @(posedge mclk);
      rd(`POLS_ADDR_VALUE, store);
      rd(`POLS_ADDR_LEVEL, ~store & ~`POLS_RSVD_MASK);
      bus(`POLS_ADDR_VALUE, 1'h1, 3'h0, ~store);
      bus(8'h40, 1'h1, `POLS_HSIZE_WORD, 32'h0000ffff);
      rd(8'h40, 32'h0);
      rd(`POLS_ADDR_CLR, store);
      reset_n <= 1'h0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'h1;
      store = 32'h0;
      funcR = 32'h0;
      dirR = 32'h0;
      @(posedge mclk);
      rd(`POLS_ADDR_VALUE, 32'h0);
      chk_pins;
      repeat (2) @(posedge mclk);
      cmp("queue", 32'h0, 32'(expQ.size()));
      test_done;
   end
endmodule // tb_top

`default_nettype wire
